/* File: common/pwmst_map.vh */
`ifndef PWMST_MAP_VH
`define PWMST_MAP_VH
// Register byte offsets
`define PWMST_ROUTE_CTRL_OFS 12'h000
`define PWMST_MODE_CTRL_OFS 12'h004
`define PWMST_STATUS_OFS 12'h008
// Route control fields
`define PWMST_SYNC_BIT 4
`define PWMST_ROUTE_LSB 0
`define PWMST_ROUTE_MSB 3
// Mode control fields
`define PWMST_POL_LSB 0
`define PWMST_POL_MSB 1
`define PWMST_CCMODE_LSB 2
`define PWMST_CCMODE_MSB 3
`define PWMST_BRIDGE_LSB 4
`define PWMST_BRIDGE_MSB 5
// Reset values
`define PWMST_ROUTE_RESET 8'h01
`define PWMST_MODE_RESET 8'h00
`define PWMST_ACTIVE_RESET 4'h1
// Enabling codes
`define PWMST_CCMODE_PWM 2'h3
`define PWMST_BRIDGE_SINGLE 2'h0
`endif

/* File: design/pwmst_pin_mux.v */
`timescale 1ns/1ps
// One steered output pin: PWM with polarity, or the port value
module pwmst_pin_mux
(
   input wire hclk,
   input wire hresetn,
   input wire steer_on,
   input wire route_bit,
   input wire pwm_level,
   input wire port_level,
   output reg pin_level
);
   // Registered so the top output comes from a flip-flop
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pin_level <= 1'b0;
      else if (steer_on && route_bit)
         pin_level <= pwm_level;
      else
         pin_level <= port_level;
   end
endmodule

/* File: design/pwmst_top.v */
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// R1: Upper three route bits read zero
// R2: Sync set defers routing to period start
// R3: Sync clear applies at instruction boundary
// R4: Bit D routes waveform to pin four
// R5: Bit C routes waveform to pin three
// R6: Bit B routes waveform to pin two
// R7: Bit A routes pin one, resets one
// R8: Steering only when mode 11, bridge 00
// R9: Shadow routing copied on update event
`include "pwmst_map.vh"
module pwmst_top
#(
   parameter PINS = 4
)
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire pwm_raw,
   input wire period_start,
   input wire instr_boundary,
   input wire [PINS-1:0] port_out,
   output wire [PINS-1:0] pwm_out_pins
);
   // ********************************
   // Bus address phase capture
   // ********************************
   reg wr_pend;
   reg [11:0] addr_q;
   wire take;
   // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY drop out
   assign take = hsel && hready && htrans[1];

   // Zero wait states: ready and response never move, so a master
   // is never stalled here. hsize is not decoded, as every register
   // is one whole word and narrower accesses are not supported.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         addr_q <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend <= take && hwrite;
         if (take)
            addr_q <= haddr[11:0];
      end
   end

   // ********************************
   // Register state
   // ********************************
   // Control words as software sees them, plus the live routing
   reg [7:0] route_ctrl;
   reg [7:0] mode_ctrl;
   reg [7:0] next_route_ctrl;
   reg [7:0] next_mode_ctrl;
   reg [3:0] route_active;
   reg update_flag;

   // ********************************
   // Register next values
   // ********************************
   // Shared by the write path and the read path, so that a read
   // issued right behind a write returns the new contents; the
   // stored value alone would still be one cycle stale then.
   always @*
   begin
      next_route_ctrl = route_ctrl;
      next_mode_ctrl = mode_ctrl;
      if (wr_pend)
      begin
         // R1: upper bits unimplemented
         if (addr_q == `PWMST_ROUTE_CTRL_OFS)
            next_route_ctrl = {3'h0, hwdata[4:0]};
         if (addr_q == `PWMST_MODE_CTRL_OFS)
            next_mode_ctrl = {2'h0, hwdata[5:0]};
      end
   end

   // ********************************
   // Register writes
   // ********************************
   // Stored at the edge that closes the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         route_ctrl <= `PWMST_ROUTE_RESET;
         mode_ctrl <= `PWMST_MODE_RESET;
      end
      else
      begin
         route_ctrl <= next_route_ctrl;
         mode_ctrl <= next_mode_ctrl;
      end
   end

   // ********************************
   // Update event select
   // ********************************
   // Sync bit picks which pulse may move the routing
   wire sync_mode;
   wire upd_event;
   assign sync_mode = route_ctrl[`PWMST_SYNC_BIT];
   // R2: period boundary when sync set
   // R3: instruction boundary otherwise
   assign upd_event = sync_mode ? period_start : instr_boundary;

   // ********************************
   // Shadow to active routing
   // ********************************
   // The pending flag sets while the stored routing differs from
   // the live one. The load wins over the set in the same cycle,
   // because the load removes the very difference being flagged.
   // R9: whole nibble moves at once, no partial routing
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         route_active <= `PWMST_ACTIVE_RESET;
         update_flag <= 1'b0;
      end
      else if (upd_event)
      begin
         route_active <= route_ctrl[`PWMST_ROUTE_MSB:`PWMST_ROUTE_LSB];
         update_flag <= 1'b0;
      end
      else if (route_active !=
               route_ctrl[`PWMST_ROUTE_MSB:`PWMST_ROUTE_LSB])
         update_flag <= 1'b1;
   end

   // ********************************
   // Polarity and mode gating
   // ********************************
   wire [1:0] pol;
   wire steer_on;
   reg [1:0] pol_level;
   assign pol = mode_ctrl[`PWMST_POL_MSB:`PWMST_POL_LSB];
   // R8: only single-output PWM mode steers
   assign steer_on =
      (mode_ctrl[`PWMST_CCMODE_MSB:`PWMST_CCMODE_LSB] == `PWMST_CCMODE_PWM)
      && (mode_ctrl[`PWMST_BRIDGE_MSB:`PWMST_BRIDGE_LSB]
          == `PWMST_BRIDGE_SINGLE);

   // Bit 0 inverts pins 1/3, bit 1 inverts pins 2/4
   always @*
   begin
      pol_level[0] = pwm_raw ^ pol[0];
      pol_level[1] = pwm_raw ^ pol[1];
   end

   // ********************************
   // Pin steering
   // ********************************
   // R4: pin four
   // R5: pin three
   // R6: pin two
   // R7: pin one
   // Pins 1/3 take polarity bit 0, pins 2/4 bit 1. The live
   // routing is four bits wide, so a PINS above four simply
   // repeats the four-pin map on the extra pins.
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi = gi + 1)
      begin : g_pin
         pwmst_pin_mux u_mux
         (
            .hclk(hclk),
            .hresetn(hresetn),
            .steer_on(steer_on),
            .route_bit(route_active[gi % 4]),
            .pwm_level(pol_level[gi % 2]),
            .port_level(port_out[gi]),
            .pin_level(pwm_out_pins[gi])
         );
      end
   endgenerate

   // ********************************
   // Read data
   // ********************************
   wire [31:0] status_word;
   // Pending flag, steering state and the live routing
   assign status_word = {26'h0000000, update_flag, steer_on, route_active};

   // Loaded at the address phase and held through the data phase;
   // unmapped offsets read as zero, and no read has side effects,
   // so software may poll the status word freely.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (take && !hwrite)
      begin
         case (haddr[11:0])
            // R1: reads zero above bit 4
            `PWMST_ROUTE_CTRL_OFS: hrdata <= {24'h000000, next_route_ctrl};
            `PWMST_MODE_CTRL_OFS: hrdata <= {24'h000000, next_mode_ctrl};
            `PWMST_STATUS_OFS: hrdata <= status_word;
            default: hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule

/* File: tb/pwmst_port_model.sv */
`timescale 1ns/1ps
// PWM source and port logic: 32-cycle period, 4-cycle instruction
module pwmst_port_model
(
   input wire hclk,
   input wire hresetn,
   output wire pwm_raw,
   output wire period_start,
   output wire instr_boundary,
   output wire [3:0] port_out
);
   reg [4:0] cnt;
   // Free count; port levels keep moving so a stuck pin shows
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         cnt <= 5'h00;
      else
         cnt <= cnt + 5'h01;
   assign pwm_raw = cnt[3] ^ cnt[0];
   assign period_start = cnt == 5'h1F;
   assign instr_boundary = cnt[1:0] == 2'h3;
   assign port_out = cnt[4:1] ^ 4'hA;
endmodule

/* File: tb/pwmst_top_monitor.sv */
`timescale 1ns/1ps
// Port checker with a shadow of the routing state
module pwmst_top_monitor
#(
   parameter PINS = 4
)
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire pwm_raw,
   input wire period_start,
   input wire instr_boundary,
   input wire [PINS-1:0] port_out,
   input wire [PINS-1:0] pwm_out_pins
);
   reg [5:0] md;
   reg [4:0] rt;
   reg [3:0] act, e;
   reg wr_r, wr_m, rd_r;
   wire tk = hsel & hready & htrans[1];
   wire s = md[3:2] == 2'h3 && md[5:4] == 2'h0;
   wire [3:0] sel = {4{s}} & act;
   // Shadow registers; active routing moves only on the chosen pulse
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         {md, rt, act, e, wr_r, wr_m, rd_r} <=
            {6'h00, 5'h01, 4'h1, 4'h0, 3'h0};
      else
      begin
         wr_r <= tk & hwrite & haddr[11:0] == 12'h000;
         wr_m <= tk & hwrite & haddr[11:0] == 12'h004;
         rd_r <= tk & !hwrite & haddr[11:0] == 12'h000;
         if (wr_r)
            rt <= hwdata[4:0];
         if (wr_m)
            md <= hwdata[5:0];
         if (rt[4] ? period_start : instr_boundary)
            act <= rt[3:0];
         e <= sel & ({2{md[1:0]}} ^ {4{pwm_raw}}) | ~sel & port_out[3:0];
      end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high:
      assert property (hreadyout) else $error("ready low");
   a_resp_okay:
      assert property (!hresp) else $error("resp not okay");
   a_route_upper0:
      assert property (rd_r |-> hrdata[7:5] == 3'h0) else $error("upper");
   a_pin1_route:
      assert property (pwm_out_pins[0] == e[0]) else $error("pin1");
   a_pin2_route:
      assert property (pwm_out_pins[1] == e[1]) else $error("pin2");
   a_pin3_route:
      assert property (pwm_out_pins[2] == e[2]) else $error("pin3");
   a_pin4_route:
      assert property (pwm_out_pins[3] == e[3]) else $error("pin4");
   a_port_hand:
      assert property ($past(hresetn) && !$past(s) |->
         pwm_out_pins == $past(port_out)) else $error("port");
endmodule
bind pwmst_top pwmst_top_monitor #(.PINS(PINS)) mon
(
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hwdata(hwdata),
   .hready(hready),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .pwm_raw(pwm_raw),
   .period_start(period_start),
   .instr_boundary(instr_boundary),
   .port_out(port_out),
   .pwm_out_pins(pwm_out_pins)
);

/* File: tb/pwm_output_steering_tb.sv */
`timescale 1ns/1ps
module pwm_output_steering_tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwm_raw;
   logic period_start, instr_boundary;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] port_out, pwm_out_pins;
   logic [31:0] haddr, hwdata, hrdata, r;
   int mismatches, n_checks;
   // Rows: offset, written byte, byte read back
   logic [27:0] rows [0:3] = '{28'h000FF1F, 28'h004FF3F, 28'h00CFF00,
      28'h0000101};
   logic [7:0] modes [0:4] = '{8'h1C, 8'h2C, 8'h3C, 8'h08, 8'h04};
   pwmst_top uut
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .pwm_raw(pwm_raw),
      .period_start(period_start),
      .instr_boundary(instr_boundary),
      .port_out(port_out),
      .pwm_out_pins(pwm_out_pins)
   );
   pwmst_port_model pm
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .pwm_raw(pwm_raw),
      .period_start(period_start),
      .instr_boundary(instr_boundary),
      .port_out(port_out)
   );
   initial
   begin
      hclk = 0;
      forever #50 hclk = ~hclk;
   end
   task automatic summarize();
      if (mismatches == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x)
      begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   // Bounded wait for hready; a hang ends the run
   task automatic wt();
      for (int i = 0; i < 20; i++)
      begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            return;
      end
      mismatches++;
      summarize();
   endtask
   // Bounded wait for a period start; returns just after that edge
   task automatic wp();
      for (int i = 0; i < 40; i++)
      begin
         @(posedge hclk);
         if (period_start === 1'b1)
            return;
      end
      mismatches++;
      summarize();
   endtask
   task automatic xf(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      r = hrdata;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] x);
      xf(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(12'h000, 32'h01);
      foreach (rows[i])
      begin
         xf(1'b1, rows[i][27:16], {24'h0, rows[i][15:8]});
         rc(rows[i][27:16], {24'h0, rows[i][7:0]});
      end
      // Every polarity, sync set and clear, status after a full period
      for (int i = 0; i < 8; i++)
      begin
         xf(1'b1, 12'h004, 32'(i % 4) | 32'h0C);
         xf(1'b1, 12'h000, {27'h0, i[2], 4'(i * 5 + 3)});
         repeat (40) @(posedge hclk);
         rc(12'h008, {28'h1, 4'(i * 5 + 3)});
      end
      foreach (modes[k])
      begin
         xf(1'b1, 12'h004, {24'h0, modes[k]});
         rc(12'h008, 32'h06);
      end
      // Sync set: held pending until the next period start
      wp();
      xf(1'b1, 12'h000, 32'h1F);
      repeat (2) @(posedge hclk);
      rc(12'h008, 32'h26);
      repeat (32) @(posedge hclk);
      rc(12'h008, 32'h0F);
      // Sync clear: applied within one instruction step
      xf(1'b1, 12'h000, 32'h03);
      repeat (4) @(posedge hclk);
      rc(12'h008, 32'h03);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(12'h000, 32'h01);
      summarize();
   end
endmodule
